// [eps_map.svh]
// Constants for the EPROM program and verify sequencer: codes, counts, bus map.
// Assumes one clock, hclk, standing in for the oscillator input.
// Contract
// - High address latched when half-select falls; low byte stable 13 clocks later.
// - Data port drives out while the address is loaded, before high voltage.
// - Raising the programming voltage turns the data port into an input.
// - Dropping the voltage enters verify; data shows 48 clocks later.
// - Verify with no programming since entry shows data within 14 clocks.
// - Code 296H user array, 292H key array, 298H programs security bit 2.
// - Pulsed strobe with high voltage programs; strobe high with the voltage at logic low verifies.
// - User verify outputs stored byte XNOR key byte.
// - Key byte chosen cyclically by address, restarting every 16 bytes.
// - Erased key bytes read all ones, so XNOR returns data unchanged.
// - Security bit 1 blocks user and key programming and key verify.
// - Security bit 2 blocks user and key verify; security read still allowed.
// - Security bit programming needs no address or data.
// - Code 29AH verifies security bits at logic levels, pulsed strobe programs bit 1.
// - Security read: data bit 7 is bit 1, bit 6 is bit 2, one when programmed.
// - After erasure every array cell and security cell holds one.
`ifndef EPS_MAP_SVH
`define EPS_MAP_SVH

`define EPS_CODE_USER      10'h296
`define EPS_CODE_KEY       10'h292
`define EPS_CODE_SEC1      10'h29A
`define EPS_CODE_SEC2      10'h298
`define EPS_CODE_BITS      4'hA
`define EPS_ADDRESS_HALF_SELECT_CLKS      4'hD
`define EPS_LOW_CLKS       4'hD
`define EPS_PULSES         5'h19
`define EPS_VERIFY_CLKS    6'h30

`define EPS_OFF_CTRL       8'h00
`define EPS_OFF_STATUS     8'h04
`define EPS_OFF_ADDR       8'h08
`define EPS_CTRL_ARM       0
`define EPS_CTRL_ERASE     1
`define EPS_ST_SEC1        8
`define EPS_ST_SEC2        9
`define EPS_ST_AVALID      10
`define EPS_ST_READY       11
`define EPS_ST_PULSE_LSB   16

`define EPS_ERASED_BYTE    8'hFF
`define EPS_INHIBIT_BYTE   8'hFF

`endif

// [eps_pkg.sv]
// Types for the EPROM program and verify sequencer.
// Assumes eps_map.svh carries the numbers.
`default_nettype none
package eps_pkg;

  typedef enum logic [4:0] {
    EPS_IDLE = 5'b00001,
    EPS_USER = 5'b00010,
    EPS_KEY  = 5'b00100,
    EPS_SEC1 = 5'b01000,
    EPS_SEC2 = 5'b10000
  } eps_mode_t;

  typedef struct packed {
    logic [2:0] hi;
    logic [7:0] lo;
  } eps_addr_t;

  typedef struct packed {
    logic       write;
    logic [7:0] offs;
  } eps_req_t;

endpackage
`default_nettype wire

// [eps_sequencer.sv]
// EPROM program and verify sequencer with an AHB-Lite control slave.
// Assumes programmer pins are synchronous to hclk; array, key and security cells
// are flip-flops that reset to the erased state.
`include "eps_map.svh"
`timescale 1ns/1ps
`default_nettype none
module eps_sequencer (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  input  wire logic        serial_code_in,
  input  wire logic        address_half_select,
  input  wire logic [7:0]  addr_port,
  input  wire logic        program_strobe_n,
  input  wire logic        program_voltage_level,
  input  wire logic [7:0]  data_port_in,
  output logic [7:0]       data_port_out,
  output logic             data_port_oe
);

  eps_pkg::eps_mode_t mode_q;
  eps_pkg::eps_addr_t addr_q;
  eps_pkg::eps_req_t  req_q;
  logic               req_valid_q;
  logic               arm_q;
  logic               erase_q;
  logic [9:0]         code_q;
  logic [3:0]         bit_cnt_q;
  logic [3:0]         address_half_select_cnt_q;
  logic               address_half_select_prev_q;
  logic [3:0]         low_cnt_q;
  logic               strobe_prev_q;
  logic               vpp_prev_q;
  logic [4:0]         pulse_cnt_q;
  logic [7:0]         data_lat_q;
  logic               prog_seen_q;
  logic [5:0]         vcnt_q;
  logic [7:0]         user_mem [0:2047];
  logic [7:0]         key_mem [0:15];
  logic               sec1_cell_q;
  logic               sec2_cell_q;
  logic               addr_valid;
  logic               ready;
  logic               commit;
  logic [7:0]         verify_byte;
  logic [7:0]         key_byte;
  logic [31:0]        rd_value;

  // Bus slave: zero wait states, always OKAY
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      req_valid_q <= 1'b0;
      req_q       <= '0;
      hrdata      <= 32'h0000_0000;
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
    end
    else
    begin
      req_valid_q <= hsel && htrans[1] && hready;
      if (hsel && htrans[1] && hready)
      begin
        req_q  <= '{write: hwrite, offs: haddr[7:0]};
        hrdata <= hwrite ? 32'h0000_0000 : rd_value;
      end
    end
  end

  always_comb
  begin
    rd_value = 32'h0000_0000;
    unique case (haddr[7:0])
      `EPS_OFF_CTRL:
        rd_value[`EPS_CTRL_ARM] = arm_q;
      `EPS_OFF_STATUS:
      begin
        rd_value[4:0]                           = mode_q;
        rd_value[`EPS_ST_SEC1]                  = ~sec1_cell_q;
        rd_value[`EPS_ST_SEC2]                  = ~sec2_cell_q;
        rd_value[`EPS_ST_AVALID]                = addr_valid;
        rd_value[`EPS_ST_READY]                 = ready;
        rd_value[`EPS_ST_PULSE_LSB+4:`EPS_ST_PULSE_LSB] = pulse_cnt_q;
      end
      `EPS_OFF_ADDR:
        rd_value[10:0] = addr_q;
      default:
        rd_value = 32'h0000_0000;
    endcase
  end

  // Control register; erase is a one-cycle strobe
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      arm_q   <= 1'b0;
      erase_q <= 1'b0;
    end
    else
    begin
      erase_q <= 1'b0;
      if (req_valid_q && req_q.write && req_q.offs == `EPS_OFF_CTRL)
      begin
        arm_q   <= hwdata[`EPS_CTRL_ARM];
        erase_q <= hwdata[`EPS_CTRL_ERASE];
      end
    end
  end

  // Mode entry: shift LSB first, match once ten bits are
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      code_q    <= 10'h000;
      bit_cnt_q <= 4'h0;
      mode_q    <= eps_pkg::EPS_IDLE;
    end
    else if (!arm_q)
    begin
      code_q    <= 10'h000;
      bit_cnt_q <= 4'h0;
      mode_q    <= eps_pkg::EPS_IDLE;
    end
    else if (mode_q == eps_pkg::EPS_IDLE)
    begin
      code_q <= {serial_code_in, code_q[9:1]};
      if (bit_cnt_q != `EPS_CODE_BITS)
        bit_cnt_q <= bit_cnt_q + 4'h1;
      else
      begin
        // Sliding match tolerates a stray leading bit
        unique case (code_q)
          `EPS_CODE_USER: mode_q <= eps_pkg::EPS_USER;
          `EPS_CODE_KEY:  mode_q <= eps_pkg::EPS_KEY;
          `EPS_CODE_SEC1: mode_q <= eps_pkg::EPS_SEC1;
          `EPS_CODE_SEC2: mode_q <= eps_pkg::EPS_SEC2;
          default:        mode_q <= eps_pkg::EPS_IDLE;
        endcase
      end
    end
  end

  // Address multiplexing on the half-select strobe
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      address_half_select_cnt_q  <= 4'h0;
      address_half_select_prev_q <= 1'b0;
      low_cnt_q   <= 4'h0;
      addr_q      <= '0;
    end
    else
    begin
      address_half_select_prev_q <= address_half_select;
      if (address_half_select)
      begin
        if (address_half_select_cnt_q != `EPS_ADDRESS_HALF_SELECT_CLKS)
          address_half_select_cnt_q <= address_half_select_cnt_q + 4'h1;
      end
      else
      begin
        address_half_select_cnt_q <= 4'h0;
      end
      if (address_half_select_prev_q && !address_half_select && address_half_select_cnt_q == `EPS_ADDRESS_HALF_SELECT_CLKS)
        addr_q.hi <= addr_port[2:0];
      addr_q.lo <= addr_port;
      // Any change of the low byte restarts the settle count
      if (address_half_select)
        low_cnt_q <= 4'h0;
      else if (addr_port != addr_q.lo)
        low_cnt_q <= 4'h1; // Change edge is the first settle clock
      else if (low_cnt_q != `EPS_LOW_CLKS)
        low_cnt_q <= low_cnt_q + 4'h1;
    end
  end

  assign addr_valid = (low_cnt_q == `EPS_LOW_CLKS);

  // Program pulse counting while the voltage is high
  assign commit = program_voltage_level && !strobe_prev_q && program_strobe_n
                  && pulse_cnt_q == `EPS_PULSES - 5'h01;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      strobe_prev_q <= 1'b1;
      vpp_prev_q    <= 1'b0;
      pulse_cnt_q   <= 5'h00;
      data_lat_q    <= `EPS_ERASED_BYTE;
      prog_seen_q   <= 1'b0;
      vcnt_q        <= 6'h00;
    end
    else
    begin
      strobe_prev_q <= program_strobe_n;
      vpp_prev_q    <= program_voltage_level;
      if (mode_q == eps_pkg::EPS_IDLE || !program_voltage_level)
        pulse_cnt_q <= 5'h00;
      else if (!strobe_prev_q && program_strobe_n && pulse_cnt_q != `EPS_PULSES)
        pulse_cnt_q <= pulse_cnt_q + 5'h01;
      if (program_voltage_level && strobe_prev_q && !program_strobe_n)
        data_lat_q <= data_port_in;
      if (mode_q == eps_pkg::EPS_IDLE)
        prog_seen_q <= 1'b0;
      else if (program_voltage_level)
        prog_seen_q <= 1'b1;
      // Verify delay restarts on every fall of the voltage
      if (program_voltage_level || (vpp_prev_q && !program_voltage_level))
        vcnt_q <= 6'h00;
      else if (vcnt_q != `EPS_VERIFY_CLKS)
        vcnt_q <= vcnt_q + 6'h01;
    end
  end

  // Nonvolatile cells; programming only clears bits
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      for (int i = 0; i < 2048; i++)
        user_mem[i] <= `EPS_ERASED_BYTE;
      for (int k = 0; k < 16; k++)
        key_mem[k] <= `EPS_ERASED_BYTE;
      sec1_cell_q <= 1'b1;
      sec2_cell_q <= 1'b1;
    end
    else if (erase_q)
    begin
      for (int i = 0; i < 2048; i++)
        user_mem[i] <= `EPS_ERASED_BYTE;
      for (int k = 0; k < 16; k++)
        key_mem[k] <= `EPS_ERASED_BYTE;
      sec1_cell_q <= 1'b1;
      sec2_cell_q <= 1'b1;
    end
    else if (commit)
    begin
      unique case (mode_q)
        eps_pkg::EPS_USER:
          if (sec1_cell_q)
            user_mem[addr_q] <= user_mem[addr_q] & data_lat_q;
        eps_pkg::EPS_KEY:
          if (sec1_cell_q)
            key_mem[addr_q.lo[3:0]] <= key_mem[addr_q.lo[3:0]] & data_lat_q;
        eps_pkg::EPS_SEC1: sec1_cell_q <= 1'b0;
        eps_pkg::EPS_SEC2: sec2_cell_q <= 1'b0;
        eps_pkg::EPS_IDLE: sec1_cell_q <= sec1_cell_q;
      endcase
    end
  end

  // Verify data path
  assign key_byte = key_mem[addr_q.lo[3:0]];
  assign ready = (mode_q == eps_pkg::EPS_SEC1 || addr_valid)
                 && (!prog_seen_q || vcnt_q == `EPS_VERIFY_CLKS);

  always_comb
  begin
    verify_byte = `EPS_INHIBIT_BYTE;
    unique case (mode_q)
      eps_pkg::EPS_USER:
        if (sec2_cell_q)
          verify_byte = ~(user_mem[addr_q] ^ key_byte);
      eps_pkg::EPS_KEY:
        if (sec1_cell_q && sec2_cell_q)
          verify_byte = key_byte;
      eps_pkg::EPS_SEC1:
        verify_byte = {~sec1_cell_q, ~sec2_cell_q, 6'h00};
      eps_pkg::EPS_SEC2: verify_byte = `EPS_INHIBIT_BYTE;
      eps_pkg::EPS_IDLE: verify_byte = `EPS_INHIBIT_BYTE;
    endcase
  end

  // Data port direction; one registered cycle of overlap on voltage rise is the
  // price of flop outputs, the programmer waits two clocks before driving data
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      data_port_oe  <= 1'b0;
      data_port_out <= `EPS_INHIBIT_BYTE;
    end
    else
    begin
      data_port_oe  <= mode_q != eps_pkg::EPS_IDLE && !program_voltage_level;
      // Blank while the port is an input at high voltage
      data_port_out <= (ready && program_strobe_n && !program_voltage_level)
                       ? verify_byte : `EPS_INHIBIT_BYTE;
    end
  end

endmodule
`default_nettype wire

// [eps_sequencer_props.sv]
// Checker for bus answers and data port timing.
// Assumes a bind onto eps_sequencer.
`timescale 1ns/1ps
`default_nettype none
module eps_sequencer_props (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic        hresp,
  input wire logic        program_strobe_n,
  input wire logic        program_voltage_level,
  input wire logic [7:0]  data_port_out,
  input wire logic        data_port_oe
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence vpp_drop;
    $fell(program_voltage_level);
  endsequence
  chk_zero_wait: assert property (hreadyout)
    else $error("wait state");
  chk_resp_okay: assert property (!hresp)
    else $error("error response");
  chk_rdata_held: assert property (!(hsel && htrans[1] && hready) |=> $stable(hrdata))
    else $error("read data moved");
  chk_vpp_input: assert property (program_voltage_level |=> !data_port_oe)
    else $error("port driven at high voltage");
  chk_drive_cause: assert property ($rose(data_port_oe) |-> !$past(program_voltage_level))
    else $error("drive without low voltage");
  chk_vpp_blank: assert property (program_voltage_level |=> data_port_out == 8'hFF)
    else $error("data at high voltage");
  // Ready needs 48 clocks after the drop, so eight blank clocks is safe
  chk_verify_delay: assert property (vpp_drop |=> (data_port_out == 8'hFF) [*8])
    else $error("verify data early");
  chk_strobe_blank: assert property (!program_strobe_n |=> data_port_out == 8'hFF)
    else $error("data during pulse");
endmodule
bind eps_sequencer eps_sequencer_props u_props (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hready(hready),
  .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
  .program_strobe_n(program_strobe_n), .program_voltage_level(program_voltage_level),
  .data_port_out(data_port_out), .data_port_oe(data_port_oe)
);
`default_nettype wire

// [eps_programmer_model.sv]
// Programmer model: mode code, address, voltage, strobe, data.
// Assumes hclk is the oscillator; released ports toggle each cycle.
`timescale 1ns/1ps
`default_nettype none
module eps_programmer_model (
  input  wire logic  hclk,
  output logic       serial_code_in,
  output logic       address_half_select,
  output logic [7:0] addr_port,
  output logic       program_strobe_n,
  output logic       program_voltage_level,
  output logic [7:0] data_port_in
);
  logic       a_drv = 1'b0;
  logic       d_drv = 1'b0;
  logic [7:0] a_val = 8'h00;
  logic [7:0] d_val = 8'h00;
  logic [7:0] junk  = 8'hA5;
  initial
  begin
    serial_code_in = 1'b0;
    address_half_select = 1'b0;
    program_strobe_n = 1'b1;
    program_voltage_level = 1'b0;
  end
  // A stale value must never pass for real data
  always @(posedge hclk) junk <= ~junk;
  assign addr_port = a_drv ? a_val : junk;
  assign data_port_in = d_drv ? d_val : ~junk;
  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
  endtask
  task automatic send_code(input logic [9:0] c);
    a_drv <= 1'b0;
    for (int i = 0; i < 10; i++)
    begin
      @(posedge hclk);
      serial_code_in <= c[i];
    end
    @(posedge hclk);
    serial_code_in <= 1'b0;
  endtask
  task automatic load_addr(input logic [10:0] a);
    @(posedge hclk);
    a_drv <= 1'b1;
    a_val <= {5'h00, a[10:8]};
    address_half_select <= 1'b1;
    tick(13);
    address_half_select <= 1'b0;
    tick(2);
    a_val <= a[7:0];
  endtask
  // Width w in clocks: 1 is prompt, larger is slow
  task automatic burn(input logic [7:0] d, input int w, input logic use_d);
    @(posedge hclk);
    program_voltage_level <= 1'b1;
    tick(2);
    d_drv <= use_d;
    d_val <= d;
    repeat (25)
    begin
      tick(w);
      program_strobe_n <= 1'b0;
      tick(w);
      program_strobe_n <= 1'b1;
    end
    tick(2);
    d_drv <= 1'b0;
    program_voltage_level <= 1'b0;
  endtask
endmodule
`default_nettype wire

// [eps_sequencer_tb.sv]
// Testbench: AHB-Lite control plus programmer model.
// Assumes the model and checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module eps_sequencer_tb;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic        hwrite;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic [31:0] r;
  logic        hready;
  logic        hresp;
  logic        ser;
  logic        sel_hi;
  logic [7:0]  aport;
  logic        pgm_n;
  logic        vpp;
  logic [7:0]  din;
  logic [7:0]  dout;
  logic        doe;
  int          failures = 0;
  int          n_checks = 0;
  eps_sequencer dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
    .hrdata(hrdata), .hresp(hresp), .serial_code_in(ser), .address_half_select(sel_hi),
    .addr_port(aport), .program_strobe_n(pgm_n), .program_voltage_level(vpp),
    .data_port_in(din), .data_port_out(dout), .data_port_oe(doe)
  );
  eps_programmer_model m (
    .hclk(hclk), .serial_code_in(ser), .address_half_select(sel_hi), .addr_port(aport),
    .program_strobe_n(pgm_n), .program_voltage_level(vpp), .data_port_in(din)
  );
  task automatic give_verdict();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h000000, a};
    hwrite <= wr;
    hsize <= 3'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic vfy(input int n, input logic [7:0] exp);
    m.tick(n);
    chk(dout, exp);
  endtask
  // Re-arming is the only way out of a mode
  task automatic enter(input logic [9:0] c);
    ahb(1'b1, 8'h00, 32'h0);
    ahb(1'b1, 8'h00, 32'h1);
    m.send_code(c);
  endtask
  initial
  begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  initial
  begin
    repeat (20000) @(posedge hclk);
    failures++;
    give_verdict();
  end
  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'h0;
    hsize = 3'h0;
    haddr = 32'h0;
    hwdata = 32'h0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    enter(10'h296);
    m.load_addr(11'h123);
    vfy(30, 8'hFF);
    chk({7'h00, doe}, 8'h01);
    m.burn(8'h5A, 1, 1'b1);
    vfy(55, 8'h5A);
    m.burn(8'hF0, 3, 1'b1);
    vfy(55, 8'h50);
    $display("user test done");
    enter(10'h292);
    m.load_addr(11'h003);
    m.burn(8'h0F, 1, 1'b1);
    vfy(55, 8'h0F);
    enter(10'h296);
    m.load_addr(11'h123);
    vfy(15, 8'hA0);
    $display("key test done");
    enter(10'h29A);
    vfy(20, 8'h00);
    m.burn(8'h00, 1, 1'b0);
    vfy(55, 8'h80);
    enter(10'h296);
    m.load_addr(11'h123);
    m.burn(8'h00, 1, 1'b1);
    vfy(55, 8'hA0);
    enter(10'h292);
    m.load_addr(11'h003);
    vfy(30, 8'hFF);
    $display("security one test done");
    enter(10'h298);
    m.burn(8'h00, 1, 1'b0);
    vfy(55, 8'hFF);
    enter(10'h29A);
    vfy(20, 8'hC0);
    enter(10'h296);
    m.load_addr(11'h123);
    vfy(30, 8'hFF);
    $display("security two test done");
    ahb(1'b0, 8'h04, 32'h0);
    chk({6'h00, r[9:8]}, 8'h03);
    chk({6'h00, hready, hresp}, 8'h02);
    ahb(1'b0, 8'h08, 32'h0);
    chk({5'h00, r[10:8]}, 8'h01);
    chk(r[7:0], 8'h23);
    ahb(1'b0, 8'h0C, 32'h0);
    chk(r[7:0], 8'h00);
    ahb(1'b1, 8'h00, 32'h2);
    enter(10'h29A);
    vfy(20, 8'h00);
    $display("erase test done");
    give_verdict();
  end
endmodule
`default_nettype wire
